// *** rtl/prom_programmer.v ***
// host-side controller that reads and programs the on-chip prom through its pins
`timescale 1ns/100ps
`default_nettype none
`include "prom_prog_defines.vh"

module prom_programmer #(
	parameter RSP_DEPTH = 2
) (
	// clock and reset
	input  wire                  clk_sys_in,
	input  wire                  resetn_in,
	// command port
	input  wire                  cmd_valid_in,
	output wire                  cmd_ready_out,
	input  wire [1:0]            cmd_op_in,
	input  wire [`PP_ADDR_W-1:0] cmd_addr_in,
	input  wire [31:0]           cmd_data_in,
	// response port
	output wire                  rsp_valid_out,
	input  wire                  rsp_ready_in,
	output wire [`PP_RSP_W-1:0]  rsp_data_out,
	// supply and mode pins
	output reg                   prom_reset_n_out,
	output reg                   vpp_on_out,
	output reg                   vpp_high_out,
	// prom strobes and address
	output reg  [`PP_ADDR_W-1:0] prom_addr_out,
	output reg                   chip_enable_n_out,
	output reg                   output_enable_n_out,
	output reg                   program_pulse_n_out,
	// two-way data bus
	input  wire [7:0]            prom_data_in,
	output reg  [7:0]            prom_data_out,
	output reg                   prom_data_oe_n_out
);

	localparam integer PULSE_CYC = `PP_PULSE_TIME_NS / `PP_CLK_PERIOD_NS;
	localparam integer PULSE_M1  = PULSE_CYC - 1;
	localparam integer SETTLE_M1 = `PP_SETTLE_CYC - 1;
	localparam integer MODE_M1   = `PP_MODE_SETTLE_CYC - 1;
	localparam integer SAMPLE_M1 = `PP_SETTLE_CYC + `PP_SYNC_CYC - 1;
	// timer loads, cut on purpose to the 11-bit timer
	localparam [10:0]  T_PULSE   = PULSE_M1[10:0];
	localparam [10:0]  T_SETTLE  = SETTLE_M1[10:0];
	localparam [10:0]  T_MODE    = MODE_M1[10:0];
	localparam [10:0]  T_SAMPLE  = SAMPLE_M1[10:0];

	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_MODE  = 4'h1;
	localparam [3:0] S_LSET  = 4'h2;
	localparam [3:0] S_LSTB  = 4'h3;
	localparam [3:0] S_LREL  = 4'h4;
	localparam [3:0] S_BSET  = 4'h5;
	localparam [3:0] S_PULSE = 4'h6;
	localparam [3:0] S_PREL  = 4'h7;
	localparam [3:0] S_VTURN = 4'h8;
	localparam [3:0] S_VSAMP = 4'h9;
	localparam [3:0] S_RESP  = 4'ha;

	// byte lane of a page word, lane 0 is the lowest address
	function [7:0] pick_byte;
		input [31:0] word;
		input [1:0]  lane;
		begin
			pick_byte = word[lane*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset release and data pin synchroniser

	reg       rst_meta;
	reg       rst_n;
	reg [7:0] din_meta;
	reg [7:0] din_sync;

	// reset asserts at once, releases after two clean edges
	always @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// the data pins are asynchronous to us; only din_sync is looked at
	always @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_meta <= 8'h00;
			din_sync <= 8'h00;
		end
		else
		begin
			din_meta <= prom_data_in;
			din_sync <= din_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	reg  [3:0]            state;
	reg  [10:0]           timer;
	reg  [1:0]            op;
	reg  [`PP_ADDR_W-1:0] base;
	reg  [31:0]           wdata;
	reg  [1:0]            idx;
	reg  [3:0]            tries;
	reg                   mism;
	reg  [`PP_RSP_W-1:0]  rsp_word;

	wire       push_ready;
	wire       push_valid = (state == S_RESP);
	wire       want_high  = (cmd_op_in != `PP_OP_READ);
	wire [7:0] exp_byte   = pick_byte(wdata, idx);
	wire       mism_now   = mism | (din_sync != exp_byte);
	wire       is_page    = (op == `PP_OP_PAGE);
	wire       timer_done = (timer == 11'h000);
	wire [3:0] first_state = (cmd_op_in == `PP_OP_READ) ? S_VTURN :
	                         (cmd_op_in == `PP_OP_PAGE) ? S_LSET : S_BSET;
	wire [3:0] op_state    = (op == `PP_OP_READ) ? S_VTURN : (is_page ? S_LSET : S_BSET);

	// no take while the internal reset copy is still low, or the command is lost
	assign cmd_ready_out = (state == S_IDLE) && rst_n;

	// page writes always start on an aligned address and walk its four bytes
	wire [`PP_ADDR_W-1:0] cur_addr = is_page ? {base[`PP_ADDR_W-1:2], idx} : base; // RL16

	always @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state               <= S_IDLE;
			timer               <= 11'h000;
			op                  <= `PP_OP_READ;
			base                <= {`PP_ADDR_W{1'b0}};
			wdata               <= 32'h00000000;
			idx                 <= 2'h0;
			tries               <= 4'h0;
			mism                <= 1'b0;
			rsp_word            <= {`PP_RSP_W{1'b0}};
			prom_reset_n_out    <= 1'b0;
			vpp_on_out          <= 1'b0;
			vpp_high_out        <= 1'b0;
			prom_addr_out       <= {`PP_ADDR_W{1'b0}};
			chip_enable_n_out   <= 1'b1;
			output_enable_n_out <= 1'b1;
			program_pulse_n_out <= 1'b1;
			prom_data_out       <= 8'h00;
			prom_data_oe_n_out  <= 1'b1;
		end
		else
		begin
			// device reset stays low: the part lives in programming mode
			prom_reset_n_out <= 1'b0; // RL1
			if (!timer_done)
				timer <= timer - 1'b1;
			case (state)
				S_IDLE:
				begin
					// standby pins, bus released
					chip_enable_n_out   <= 1'b1; // RL4
					output_enable_n_out <= 1'b1;
					program_pulse_n_out <= 1'b1;
					prom_data_oe_n_out  <= 1'b1;
					idx   <= 2'h0;
					tries <= 4'h0;
					mism  <= 1'b0;
					if (cmd_valid_in)
					begin
						op    <= cmd_op_in;
						base  <= (cmd_op_in == `PP_OP_PAGE) ? {cmd_addr_in[`PP_ADDR_W-1:2], 2'h0} :
						         cmd_addr_in;
						wdata <= cmd_data_in;
						if (want_high && cmd_addr_in > `PP_LAST_ADDR)
						begin
							// writes past the top of the array are refused outright
							rsp_word <= {1'b1, 1'b0, 8'h00}; // RL12
							state    <= S_RESP;
						end
						else if (!vpp_on_out || vpp_high_out != want_high)
						begin
							// supply change needs time to settle before any strobe
							vpp_on_out   <= 1'b1; // RL1
							vpp_high_out <= want_high; // RL13
							timer        <= T_MODE;
							state        <= S_MODE;
						end
						else
						begin
							timer <= T_SETTLE;
							state <= first_state;
						end
					end
				end
				S_MODE:
					if (timer_done)
					begin
						timer <= T_SETTLE;
						state <= op_state;
					end
				S_LSET:
				begin
					// present one address/data pair of the page, strobes idle
					chip_enable_n_out   <= 1'b1;
					output_enable_n_out <= 1'b1;
					program_pulse_n_out <= 1'b1;
					prom_addr_out       <= cur_addr;
					prom_data_out       <= exp_byte;
					prom_data_oe_n_out  <= 1'b0;
					if (timer_done)
					begin
						timer <= T_SETTLE;
						state <= S_LSTB;
					end
				end
				S_LSTB:
				begin
					// oe low with ce and pulse high latches the pair
					output_enable_n_out <= 1'b0; // RL5
					if (timer_done)
					begin
						timer <= T_SETTLE;
						state <= S_LREL;
					end
				end
				S_LREL:
				begin
					output_enable_n_out <= 1'b1;
					if (timer_done)
					begin
						// the last byte hands over straight to the full-length pulse
						timer <= (idx == 2'h3) ? T_PULSE : T_SETTLE; // RL6
						idx   <= idx + 2'h1;
						// all four bytes must be latched before the pulse
						state <= (idx == 2'h3) ? S_PULSE : S_LSET; // RL5
					end
				end
				S_BSET:
				begin
					// byte write setup: ce low, oe high, data driven
					chip_enable_n_out   <= 1'b0; // RL7
					output_enable_n_out <= 1'b1;
					program_pulse_n_out <= 1'b1;
					prom_addr_out       <= base;
					prom_data_out       <= wdata[7:0];
					prom_data_oe_n_out  <= 1'b0;
					if (timer_done)
					begin
						timer <= T_PULSE;
						state <= S_PULSE;
					end
				end
				S_PULSE:
				begin
					// page: ce and oe high; byte: ce low, oe high
					chip_enable_n_out   <= is_page; // RL6
					output_enable_n_out <= 1'b1; // RL7
					program_pulse_n_out <= 1'b0;
					if (timer_done)
					begin
						timer <= T_SETTLE;
						tries <= tries + 4'h1; // RL10
						mism  <= 1'b0;
						idx   <= 2'h0;
						state <= S_PREL;
					end
				end
				S_PREL:
				begin
					program_pulse_n_out <= 1'b1;
					if (timer_done)
					begin
						timer <= T_SETTLE;
						state <= S_VTURN;
					end
				end
				S_VTURN:
				begin
					// release the bus a while before oe falls, so no fight on the pins
					prom_data_oe_n_out  <= 1'b1; // RL3
					output_enable_n_out <= 1'b1;
					chip_enable_n_out   <= 1'b0; // RL9
					program_pulse_n_out <= 1'b1;
					prom_addr_out       <= cur_addr; // RL13
					if (timer_done)
					begin
						timer <= T_SAMPLE;
						state <= S_VSAMP;
					end
				end
				S_VSAMP:
				begin
					// device now drives; wait settle plus synchroniser depth
					output_enable_n_out <= 1'b0; // RL9
					if (timer_done)
					begin
						timer <= T_SETTLE;
						if (op == `PP_OP_READ)
						begin
							rsp_word <= {1'b0, din_sync == `PP_ERASED, din_sync}; // RL14
							state    <= S_RESP;
						end
						else if (is_page && idx != 2'h3)
						begin
							mism  <= mism_now; // RL15
							idx   <= idx + 2'h1;
							state <= S_VTURN;
						end
						else if (!mism_now)
						begin
							rsp_word <= {1'b0, 1'b0, 4'h0, tries}; // RL15
							state    <= S_RESP;
						end
						else if (tries == `PP_MAX_TRY)
						begin
							rsp_word <= {1'b1, 1'b0, 4'h0, tries}; // RL10
							state    <= S_RESP;
						end
						else
						begin
							// another pulse; the page latch is reloaded to be safe
							idx   <= 2'h0;
							mism  <= 1'b0;
							state <= op_state; // RL10
						end
					end
				end
				S_RESP:
				begin
					chip_enable_n_out   <= 1'b1;
					output_enable_n_out <= 1'b1;
					// a stalled receiver holds us here; nothing is dropped
					if (push_ready)
						state <= S_IDLE;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// response buffer

	pair_fifo #(
		.WIDTH (`PP_RSP_W),
		.DEPTH (RSP_DEPTH)
	) u_rsp_fifo (
		.clk_in        (clk_sys_in),
		.rst_n_in      (rst_n),
		.in_valid_in   (push_valid),
		.in_ready_out  (push_ready),
		.in_data_in    (rsp_word),
		.out_valid_out (rsp_valid_out),
		.out_ready_in  (rsp_ready_in),
		.out_data_out  (rsp_data_out)
	);

endmodule // prom_programmer

`default_nettype wire

// *** pkg/prom_prog_defines.vh ***
// constants for the pin-driven prom programming controller
// Functional notes
// RL1: programming mode is entered with the supply pin at +5 V or +12.5 V and reset held low, both set up before any operation.
// RL2: with chip enable and output enable low the device drives the stored byte of the presented address.
// RL3: with output enable high the device leaves its data pins at high impedance.
// RL4: with chip enable high and no write pulse the device is in standby with its data pins floating.
// RL5: chip enable high, program pulse high and output enable low latches address and data into a four-byte page latch.
// RL6: after four bytes are latched, chip enable and output enable high with a 0.1 ms low program pulse writes the page.
// RL7: chip enable low, output enable high and a 0.1 ms low program pulse writes one byte.
// RL8: chip enable low, program pulse high and output enable low after a write drives back the programmed contents.
// RL9: a page write is verified with chip enable and output enable low, a byte write with output enable low.
// RL10: a failing location is pulsed and verified again, at most 10 times in all.
// RL11: a device with its program pulse held high is not written and keeps its data pins floating.
// RL12: writes cover 0000h to efffh and the last address efffh is given explicitly.
// RL13: a read holds reset low, supplies +5 V, presents A0 to A16, selects read mode and samples the data.
// RL14: an erased location reads back as ffh.
// RL15: verify data is compared with the intended bytes before moving on to the next address or page.
// RL16: a page write presents four consecutive addresses of one aligned page before the pulse.
`ifndef PROM_PROG_DEFINES_VH
`define PROM_PROG_DEFINES_VH

// timing, in its own unit and the system clock period
`define PP_CLK_PERIOD_NS	100
`define PP_PULSE_TIME_NS	100000
`define PP_SETTLE_CYC	4
`define PP_MODE_SETTLE_CYC	16
`define PP_SYNC_CYC	2

// address map and data values
`define PP_ADDR_W	17
`define PP_LAST_ADDR	17'h0efff
`define PP_ERASED	8'hff
`define PP_MAX_TRY	4'ha

// command codes
`define PP_OP_READ	2'h0
`define PP_OP_BYTE	2'h1
`define PP_OP_PAGE	2'h2

// response word fields
`define PP_RSP_W	10
`define PP_RSP_ERR	9
`define PP_RSP_BLANK	8

`endif

// *** rtl/pair_fifo.v ***
// small valid/ready fifo used as the response buffer
`timescale 1ns/100ps
`default_nettype none

module pair_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 2
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             rst_n_in,
	// fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);

	function integer clog2;
		input integer v;
		integer n;
		begin
			n = 0;
			while ((1 << n) < v)
				n = n + 1;
			clog2 = (n < 1) ? 1 : n;
		end
	endfunction

	localparam AW = clog2(DEPTH);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	reg [AW:0]      count;

	wire do_wr = in_valid_in && in_ready_out;
	wire do_rd = out_valid_out && out_ready_in;

	// honest flags straight from the fill count
	assign in_ready_out  = (count != DEPTH[AW:0]);
	assign out_valid_out = (count != {(AW+1){1'b0}});
	assign out_data_out  = mem[rd_ptr[AW-1:0]];

	// storage has no reset; it is never read while empty
	always @(posedge clk_in)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data_in;
	end

	// pointers wrap at depth so any depth works, not only powers of two
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_wr)
				wr_ptr <= (wr_ptr == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}} : wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= (rd_ptr == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}} : rd_ptr + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end

endmodule // pair_fifo

`default_nettype wire

// *** tb/prom_device_model.sv ***
// behavioural prom in programming mode, with a write fault switch
`timescale 1ns/100ps
`default_nettype none
module prom_device_model (
	// mode, strobe and address pins
	input  wire logic        reset_n_in,
	input  wire logic        vpp_on_in,
	input  wire logic        vpp_high_in,
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        pgm_n_in,
	input  wire logic [16:0] addr_in,
	// host drive and fault control
	input  wire logic [7:0]  host_data_in,
	input  wire logic        host_oe_n_in,
	input  wire logic        fail_in,
	// resolved data pins
	output logic      [7:0]  bus_out
);
	logic [7:0]  mem [0:131071];
	logic [7:0]  lat_d [0:3];
	logic [16:0] lat_a [0:3];
	logic [7:0]  last, bd;
	logic [16:0] ba;
	logic        page, ok;
	realtime     t_fall;
	wire prog = !reset_n_in && vpp_on_in;
	wire drv = prog && !ce_n_in && !oe_n_in && pgm_n_in;
	////////////////////////////////////////////////////////////////////////
	// erased array, empty latch
	initial
	begin
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'hff;
		for (int k = 0; k < 4; k++)
		begin
			lat_d[k] = 8'hff;
			lat_a[k] = 17'h0;
		end
		ok = 1'b0;
		last = 8'h00;
	end
	// latch follows the bus while latch mode holds
	always @*
		if (prog && ce_n_in && !oe_n_in && pgm_n_in && !host_oe_n_in)
		begin
			lat_d[addr_in[1:0]] = host_data_in;
			lat_a[addr_in[1:0]] = addr_in;
		end
	// judged mid-cycle so that pins updated with the strobe have landed
	always @(negedge pgm_n_in)
	begin
		t_fall = $realtime;
		#50;
		ok = prog && vpp_high_in && oe_n_in && !fail_in;
		page = ce_n_in;
		bd = host_data_in;
		ba = addr_in;
	end
	// a short pulse programs nothing; bits only clear
	always @(posedge pgm_n_in)
		if (ok && $realtime - t_fall >= 100000.0)
		begin
			if (page)
				for (int k = 0; k < 4; k++)
					mem[lat_a[k]] = mem[lat_a[k]] & lat_d[k];
			else
				mem[ba] = mem[ba] & bd;
		end
	////////////////////////////////////////////////////////////////////////
	// released pins show the inverse of the last driven value
	always @*
		if (!host_oe_n_in || drv)
			last = !host_oe_n_in ? host_data_in : mem[addr_in];
	assign bus_out = !host_oe_n_in ? host_data_in : drv ? mem[addr_in] : ~last;
endmodule // prom_device_model
`default_nettype wire

// *** tb/prom_programmer_props.sv ***
// pin and handshake checks for the prom programmer
`timescale 1ns/100ps
`default_nettype none
`include "prom_prog_defines.vh"
module prom_programmer_props (
	// clock, reset, handshakes
	input wire logic                  clk_sys_in,
	input wire logic                  resetn_in,
	input wire logic                  cmd_valid_in,
	input wire logic                  cmd_ready_out,
	input wire logic                  rsp_valid_out,
	input wire logic                  rsp_ready_in,
	input wire logic [`PP_RSP_W-1:0]  rsp_data_out,
	// device pins
	input wire logic                  prom_reset_n_out,
	input wire logic                  vpp_on_out,
	input wire logic                  vpp_high_out,
	input wire logic [`PP_ADDR_W-1:0] prom_addr_out,
	input wire logic                  chip_enable_n_out,
	input wire logic                  output_enable_n_out,
	input wire logic                  program_pulse_n_out,
	input wire logic                  prom_data_oe_n_out
);
	int unsigned lo_cnt;
	int unsigned n_pulse;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////////////
	// pulse length and pulses per command, too long to unroll
	always_ff @(posedge clk_sys_in or negedge resetn_in)
		if (!resetn_in)
		begin
			lo_cnt <= 0;
			n_pulse <= 0;
		end
		else
		begin
			lo_cnt <= program_pulse_n_out ? 0 : lo_cnt + 1;
			if (cmd_valid_in && cmd_ready_out)
				n_pulse <= 0;
			else if (!program_pulse_n_out && lo_cnt == 0)
				n_pulse <= n_pulse + 1;
		end
	////////////////////////////////////////////////////////////////////////
	a_mode_entry: assert property (vpp_on_out |-> !prom_reset_n_out)
		else $error("supply on with device reset high");
	a_pulse_width: assert property ($rose(program_pulse_n_out) |-> lo_cnt >= 1000 && lo_cnt <= 1010)
		else $error("program pulse length wrong");
	a_pulse_mode: assert property (!program_pulse_n_out |-> vpp_on_out && vpp_high_out && output_enable_n_out)
		else $error("pulse without write supply or with oe low");
	a_pulse_hold: assert property (!program_pulse_n_out && $past(!program_pulse_n_out) |-> $stable(chip_enable_n_out))
		else $error("chip enable moved during pulse");
	a_write_range: assert property ($fell(program_pulse_n_out) && !chip_enable_n_out |-> prom_addr_out <= `PP_LAST_ADDR)
		else $error("byte write above last address");
	a_no_fight: assert property (!chip_enable_n_out && !output_enable_n_out |-> prom_data_oe_n_out)
		else $error("host drives while device outputs");
	a_release_early: assert property ($fell(output_enable_n_out) && !chip_enable_n_out |-> $past(prom_data_oe_n_out, 4))
		else $error("data not released before read strobe");
	a_latch_drive: assert property (chip_enable_n_out && !output_enable_n_out |-> !prom_data_oe_n_out && program_pulse_n_out)
		else $error("page latch without data drive");
	a_try_limit: assert property (n_pulse <= 10)
		else $error("more than ten pulses for one command");
	a_one_cmd: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out)
		else $error("ready stayed high after take");
	a_rsp_hold: assert property (rsp_valid_out && !rsp_ready_in |=> rsp_valid_out && $stable(rsp_data_out))
		else $error("response changed before consumed");
	c_page: cover property (!program_pulse_n_out && chip_enable_n_out);
	c_byte: cover property (!program_pulse_n_out && !chip_enable_n_out);
	c_stall: cover property (rsp_valid_out && !rsp_ready_in && !cmd_ready_out);
	c_read: cover property ($fell(output_enable_n_out) && !vpp_high_out);
endmodule // prom_programmer_props
bind prom_programmer prom_programmer_props prom_programmer_props_i (.clk_sys_in, .resetn_in,
	.cmd_valid_in, .cmd_ready_out, .rsp_valid_out, .rsp_ready_in, .rsp_data_out,
	.prom_reset_n_out, .vpp_on_out, .vpp_high_out, .prom_addr_out, .chip_enable_n_out,
	.output_enable_n_out, .program_pulse_n_out, .prom_data_oe_n_out);
`default_nettype wire

// *** tb/prom_programmer_tb.sv ***
// self-checking bench: programmer against the device model
`timescale 1ns/100ps
`default_nettype none
`include "prom_prog_defines.vh"
module prom_programmer_tb;
	typedef struct packed {logic [1:0] op; logic [16:0] a; logic [31:0] d;
		logic f; logic [9:0] e; logic [9:0] m;} row_t;
	logic        clk_sys_in, resetn_in, cmd_valid_in, rsp_ready_in, fail;
	logic [1:0]  cmd_op_in;
	logic [16:0] cmd_addr_in, addr;
	logic [31:0] cmd_data_in;
	logic        cmd_ready, rsp_valid, rst_n, vpp_on, vpp_hi, ce_n, oe_n, pgm_n, doe_n;
	logic [9:0]  rsp, r;
	logic [7:0]  dout, din;
	int          n_fail, checks_done;
	// op, address, data, fault, expected answer, compare mask
	row_t rows [13] = '{
		'{2'h0, 17'h00010, 32'h0, 1'b0, 10'h1ff, 10'h3ff},
		'{2'h1, 17'h0efff, 32'h5a, 1'b0, 10'h001, 10'h3ff},
		'{2'h0, 17'h0efff, 32'h0, 1'b0, 10'h05a, 10'h3ff},
		'{2'h2, 17'h00106, 32'h44332211, 1'b0, 10'h001, 10'h3ff},
		'{2'h0, 17'h00104, 32'h0, 1'b0, 10'h011, 10'h3ff},
		'{2'h0, 17'h00107, 32'h0, 1'b0, 10'h044, 10'h3ff},
		'{2'h0, 17'h00103, 32'h0, 1'b0, 10'h1ff, 10'h3ff},
		'{2'h1, 17'h0f000, 32'h77, 1'b0, 10'h200, 10'h200},
		'{2'h0, 17'h1ffff, 32'h0, 1'b0, 10'h1ff, 10'h3ff},
		'{2'h3, 17'h00030, 32'ha5, 1'b0, 10'h001, 10'h3ff},
		'{2'h0, 17'h00030, 32'h0, 1'b0, 10'h0a5, 10'h3ff},
		'{2'h1, 17'h00020, 32'h0, 1'b1, 10'h20a, 10'h20f},
		'{2'h0, 17'h00020, 32'h0, 1'b0, 10'h1ff, 10'h3ff}};
	prom_programmer prom_programmer_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .rsp_valid_out(rsp_valid),
		.rsp_ready_in(rsp_ready_in), .rsp_data_out(rsp), .prom_reset_n_out(rst_n),
		.vpp_on_out(vpp_on), .vpp_high_out(vpp_hi), .prom_addr_out(addr),
		.chip_enable_n_out(ce_n), .output_enable_n_out(oe_n), .program_pulse_n_out(pgm_n),
		.prom_data_in(din), .prom_data_out(dout), .prom_data_oe_n_out(doe_n));
	prom_device_model prom_device_model_i (.reset_n_in(rst_n), .vpp_on_in(vpp_on),
		.vpp_high_in(vpp_hi), .ce_n_in(ce_n), .oe_n_in(oe_n), .pgm_n_in(pgm_n),
		.addr_in(addr), .host_data_in(dout), .host_oe_n_in(doe_n), .fail_in(fail),
		.bus_out(din));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// valid held until ready is seen at the taking edge
	task automatic send(input logic [1:0] op, input logic [16:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		#10;
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_valid_in = 1'b1;
		@(negedge clk_sys_in);
		for (int k = 0; k < 30000 && cmd_ready !== 1'b1; k++)
			@(negedge clk_sys_in);
		if (cmd_ready !== 1'b1)
			n_fail++;
		@(posedge clk_sys_in);
		#10;
		cmd_valid_in = 1'b0;
	endtask
	// ready raised for exactly one edge, so one word pops
	task automatic get(output logic [9:0] w);
		@(negedge clk_sys_in);
		for (int k = 0; k < 30000 && rsp_valid !== 1'b1; k++)
			@(negedge clk_sys_in);
		if (rsp_valid !== 1'b1)
			n_fail++;
		w = rsp;
		@(posedge clk_sys_in);
		#10;
		rsp_ready_in = 1'b1;
		@(posedge clk_sys_in);
		#10;
		rsp_ready_in = 1'b0;
	endtask
	// strobes idle and supply off while reset is held three cycles
	task automatic do_reset;
		@(posedge clk_sys_in);
		#10;
		resetn_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		check({3'h0, cmd_ready, rsp_valid, ce_n, oe_n, pgm_n, doe_n, vpp_on}, 10'h01e);
		#10;
		resetn_in = 1'b1;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	// watchdog, about three times the expected run
	initial
	begin
		#(40000 * 100);
		n_fail++;
		final_report;
	end
	initial
	begin
		{cmd_valid_in, rsp_ready_in, fail, cmd_op_in} = 5'h0;
		cmd_addr_in = 17'h0;
		cmd_data_in = 32'h0;
		resetn_in = 1'b0;
		n_fail = 0;
		checks_done = 0;
		do_reset();
		for (int i = 0; i < 13; i++)
		begin
			fail = rows[i].f;
			send(rows[i].op, rows[i].a, rows[i].d);
			get(r);
			check(r & rows[i].m, rows[i].e);
			$display("row %0d done", i);
		end
		// two answers parked, third command then stalls the controller
		send(2'h0, 17'h0efff, 32'h0);
		send(2'h0, 17'h00104, 32'h0);
		send(2'h0, 17'h00105, 32'h0);
		repeat (200) @(negedge clk_sys_in);
		check({8'h0, cmd_ready, rsp_valid}, 10'h001);
		get(r);
		check(r, 10'h05a);
		get(r);
		check(r, 10'h011);
		get(r);
		check(r, 10'h022);
		$display("fifo test done");
		// reset in mid-run keeps the array and recovers
		do_reset();
		send(2'h0, 17'h0efff, 32'h0);
		get(r);
		check(r, 10'h05a);
		$display("reset test done");
		final_report;
	end
endmodule // prom_programmer_tb
`default_nettype wire
